/* File: pkg/lhb_pkg.sv */
package lhb_pkg;
  // Register byte offsets
  localparam logic [3:0]  CTRL_OFS    = 4'h0;
  localparam logic [3:0]  ALLOW_OFS   = 4'h4;
  localparam logic [3:0]  STATUS_OFS  = 4'h8;
  // Control fields
  localparam int          OMIT_BIT    = 0;
  localparam int          SHORT_BIT   = 1;
  localparam int          SEQ_OK_BIT  = 2;
  localparam int          CRC_OK_BIT  = 3;
  localparam int          TAGLEN_LSB  = 4;
  localparam int          DEFTYPE_LSB = 16;
  localparam logic [31:0] CTRL_RESET  = 32'h0800_0000;
  localparam logic [31:0] ALLOW_RESET = 32'h0000_0000;
  // Status fields
  localparam int          ERR_BIT     = 0;
  localparam int          BUSY_BIT    = 1;
  localparam int          EXT_BIT     = 2;
  localparam int          TYPE_LSB    = 16;
  // Short codes and permission classes
  localparam logic [7:0]  TABLE_TOP   = 8'h19;
  localparam logic [7:0]  IPANY_CODE  = 8'h30;
  localparam logic [7:0]  VLAN_CODE   = 8'h31;
  localparam logic [7:0]  SIG_LO      = 8'h42;
  localparam logic [7:0]  SIG_HI      = 8'h47;
  localparam logic [7:0]  USER_LO     = 8'h80;
  localparam logic [7:0]  ESC_CODE    = 8'hff;
  localparam logic [4:0]  IP_CLASS    = 5'd26;
  localparam logic [4:0]  VLAN_CLASS  = 5'd27;
  localparam logic [4:0]  SIG_CLASS   = 5'd28;
  localparam logic [4:0]  USER_CLASS  = 5'd29;
  localparam logic [4:0]  ESC_CLASS   = 5'd30;
  localparam logic [4:0]  RSVD_CLASS  = 5'd31;
  // Full types
  localparam logic [15:0] VLAN_TYPE   = 16'h8100;
  localparam logic [15:0] IPV4_TYPE   = 16'h0800;
  localparam logic [15:0] IPV6_TYPE   = 16'h86dd;
  localparam logic [15:0] EXT_LIMIT   = 16'h0600;
  localparam logic [3:0]  IPV4_VER    = 4'h4;
  localparam logic [3:0]  IPV6_VER    = 4'h6;
  localparam logic [2:0]  CRC_LAST    = 3'd3;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_CODE  = 3'b001,
    ST_TAG   = 3'b010,
    ST_TYPEH = 3'b011,
    ST_TYPEL = 3'b100,
    ST_DATA  = 3'b101,
    ST_TRAIL = 3'b110,
    ST_DRAIN = 3'b111
  } lhb_state_type;
endpackage

/* File: hw/lhb_core.sv */
// Design decisions made here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/100ps
// Behaviour
// - Emit 8-bit short code when configured; omit it when the type omit flag is set
// - Only emit short codes whose protocol type is permitted by configuration
// - Zero-length code: type is controller default unless tag length code implies one
// - Map short codes to full 16-bit types by fixed table; full type feeds CRC
// - Code 0x30 resolves to 0x0800 or 0x86DD from payload IP version
// - Code 0x31 is VLAN like 0x0F without inner 2-byte type
// - Codes 0x42..0x47 mark internal signalling payloads
// - Code 0xFF: full 2-byte type follows the tag bytes
// - Full type present unless omitted or a non-escape short code used
// - Full type sent MSB first, only a permitted type (the core checks no allow bit against the full type itself)
// - Full type may indicate an extension header instead of a protocol
// - Tag byte count follows the tag length code, maybe controller length
// - All payload octets sent in order, contiguous, no gaps
// - Integrity trailer only for split units, never for single piece
// - Split trailer is sequence byte or CRC, never both
// - Integrity select zero in first piece means sequence trailer
// - Sequence trailer only when controller permits it
// - Per-slot sequence counter, zero after logon, plus one per split unit sent with a sequence trailer, mod 256
// - Full type below 0x600 is an extension header indication (for code 0x30 the flag comes from req_type, not the resolved type)
// - CRC covers the 16-bit full type even if omitted or shortened, plus tags
// - Reassembly slot is the last three bits of piece header
module lhb_core #(
  parameter int SLOTS = 8
) (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [15:0] req_type,
  input  wire logic [7:0]  req_code,
  input  wire logic [1:0]  req_tag_code,
  input  wire logic [31:0] req_tag,
  input  wire logic        req_split,
  input  wire logic        req_use_crc,
  input  wire logic [2:0]  req_slot,
  input  wire logic        sdu_valid,
  output logic             sdu_ready,
  input  wire logic [7:0]  sdu_data,
  input  wire logic        sdu_last,
  input  wire logic [31:0] crc_value,
  output logic             out_valid,
  input  wire logic        out_ready,
  output logic      [7:0]  out_data,
  output logic             out_last,
  output logic             integrity_sel,
  output logic      [15:0] crc_type,
  output logic             cfg_error
);
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [4:0] code_class(input logic [7:0] c);
    if (c <= lhb_pkg::TABLE_TOP) return c[4:0];
    if (c == lhb_pkg::IPANY_CODE) return lhb_pkg::IP_CLASS;
    if (c == lhb_pkg::VLAN_CODE) return lhb_pkg::VLAN_CLASS;
    if (c >= lhb_pkg::SIG_LO && c <= lhb_pkg::SIG_HI) return lhb_pkg::SIG_CLASS;
    if (c == lhb_pkg::ESC_CODE) return lhb_pkg::ESC_CLASS;
    if (c >= lhb_pkg::USER_LO) return lhb_pkg::USER_CLASS;
    return lhb_pkg::RSVD_CLASS;
  endfunction

  function automatic logic [15:0] short_to_full(input logic [7:0] c, input logic [15:0] t);
    case (c)
      8'h00: return 16'h0000;
      8'h01: return 16'h0001;
      8'h02: return 16'h0002;
      8'h03: return 16'h0003;
      8'h04: return 16'h00c8;
      8'h05: return 16'h0100;
      8'h06: return 16'h0200;
      8'h07: return 16'h0300;
      8'h08: return 16'h0301;
      8'h09: return 16'h03c3;
      8'h0a: return 16'h0400;
      8'h0b: return 16'h04c2;
      8'h0c: return 16'h0500;
      8'h0d: return 16'h0800;
      8'h0e: return 16'h0806;
      8'h0f: return 16'h8100;
      8'h10: return 16'h22f1;
      8'h11: return 16'h86dd;
      8'h12: return 16'h8809;
      8'h13: return 16'h8847;
      8'h14: return 16'h8848;
      8'h15: return 16'h8863;
      8'h16: return 16'h8864;
      8'h17: return 16'h888e;
      8'h18: return 16'h8906;
      8'h19: return 16'h88a8;
      8'h31: return lhb_pkg::VLAN_TYPE;
      default: return t;
    endcase
  endfunction

  function automatic logic [2:0] tag_count(input logic [1:0] tc, input logic [2:0] ctl);
    case (tc)
      2'd1:    return ctl;
      2'd2:    return 3'd1;
      default: return 3'd0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  lhb_pkg::lhb_state_type state;
  logic [31:0] ctrl;
  logic [31:0] allow;
  logic        ext_flag;
  logic [15:0] u_type;
  logic [7:0]  u_code;
  logic        u_omit;
  logic        u_type_first;
  logic        u_emit_type;
  logic        u_split;
  logic        u_crc;
  logic        u_first;
  logic [2:0]  u_slot;
  logic [31:0] u_tag;
  logic [2:0]  u_tag_n;
  logic [2:0]  cnt;
  logic [7:0]  seq [SLOTS];

  wire         bus_req     = avs_read | avs_write;
  wire         bus_do      = bus_req & ~avs_waitrequest;
  wire         wr_ctrl     = bus_do & avs_write & (avs_address == lhb_pkg::CTRL_OFS);
  wire         wr_allow    = bus_do & avs_write & (avs_address == lhb_pkg::ALLOW_OFS);
  wire         wr_status   = bus_do & avs_write & (avs_address == lhb_pkg::STATUS_OFS);
  wire  [31:0] be_mask     = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                              {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire  [31:0] status_word = {crc_type, 13'h0000, ext_flag, (state != lhb_pkg::ST_IDLE),
                              cfg_error};
  wire  [31:0] rd_mux      = (avs_address == lhb_pkg::CTRL_OFS)   ? ctrl :
                             (avs_address == lhb_pkg::ALLOW_OFS)  ? allow :
                             (avs_address == lhb_pkg::STATUS_OFS) ? status_word : 32'h0000_0000;

  wire         take_req    = req_valid & req_ready;
  wire         take_sdu    = sdu_valid & sdu_ready;
  wire         slot_free   = ~out_valid | out_ready;
  wire         c_omit      = ctrl[lhb_pkg::OMIT_BIT];
  wire         c_short     = ctrl[lhb_pkg::SHORT_BIT] & ~c_omit;
  wire  [4:0]  req_class   = code_class(req_code);
  wire         code_bad    = c_short & ((req_class == lhb_pkg::RSVD_CLASS) |
                                        ~allow[req_class]);
  wire         trail_crc   = req_use_crc & ctrl[lhb_pkg::CRC_OK_BIT];
  wire         trail_bad   = req_split & ~trail_crc & ~ctrl[lhb_pkg::SEQ_OK_BIT];
  wire         req_bad     = code_bad | trail_bad;
  wire         req_esc     = c_short & (req_code == lhb_pkg::ESC_CODE);
  wire  [15:0] omit_type   = (req_tag_code == 2'd3) ? req_type
                                                    : ctrl[lhb_pkg::DEFTYPE_LSB +: 16];
  wire  [15:0] req_full    = c_omit ? omit_type :
                             (c_short & ~req_esc) ? short_to_full(req_code, req_type)
                                                  : req_type;
  wire  [7:0]  cur_seq     = seq[u_slot];
  wire         tag_busy    = (state == lhb_pkg::ST_TAG) & (cnt != u_tag_n);
  wire         hdr_load    = slot_free & ((state == lhb_pkg::ST_CODE) | tag_busy |
                             (state == lhb_pkg::ST_TYPEH) | (state == lhb_pkg::ST_TYPEL) |
                             (state == lhb_pkg::ST_TRAIL));
  wire         data_load   = take_sdu & (state == lhb_pkg::ST_DATA);
  wire         seq_last    = hdr_load & (state == lhb_pkg::ST_TRAIL) & ~u_crc;
  wire         crc_last    = hdr_load & (state == lhb_pkg::ST_TRAIL) & u_crc &
                             (cnt == lhb_pkg::CRC_LAST);
  wire  [7:0]  trail_byte  = u_crc ? crc_value[8'(31 - 8 * cnt) -: 8] : cur_seq;
  wire  [7:0]  next_byte   = (state == lhb_pkg::ST_CODE)  ? u_code :
                             (state == lhb_pkg::ST_TAG)   ? u_tag[31:24] :
                             (state == lhb_pkg::ST_TYPEH) ? u_type[15:8] :
                             (state == lhb_pkg::ST_TYPEL) ? u_type[7:0] :
                             (state == lhb_pkg::ST_TRAIL) ? trail_byte : sdu_data;
  wire         next_last   = seq_last | crc_last | (data_load & sdu_last & ~u_split);
  wire         next_sdu_ready = ((state == lhb_pkg::ST_DATA) & slot_free & ~take_sdu) |
                                ((state == lhb_pkg::ST_DRAIN) & ~(take_sdu & sdu_last));
  wire  [15:0] ip_type     = (sdu_data[7:4] == lhb_pkg::IPV6_VER) ? lhb_pkg::IPV6_TYPE
                                                                 : lhb_pkg::IPV4_TYPE;
  wire         ip_resolve  = data_load & u_first & ~u_omit &
                             (u_code == lhb_pkg::IPANY_CODE) & ~u_emit_type;

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
      ctrl            <= lhb_pkg::CTRL_RESET;
      allow           <= lhb_pkg::ALLOW_RESET;
      cfg_error       <= 1'b0;
    end else begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
      avs_readdata    <= (avs_read & avs_waitrequest) ? rd_mux : avs_readdata;
      if (wr_ctrl) begin
        ctrl <= (ctrl & ~be_mask) | (avs_writedata & be_mask);
      end
      if (wr_allow) begin
        allow <= (allow & ~be_mask) | (avs_writedata & be_mask);
      end
      if (take_req & req_bad) begin
        cfg_error <= 1'b1;
      end else if (wr_status & avs_byteenable[0] & avs_writedata[lhb_pkg::ERR_BIT]) begin
        cfg_error <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output stage and payload handshake
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      out_valid <= 1'b0;
      out_data  <= 8'h00;
      out_last  <= 1'b0;
      sdu_ready <= 1'b0;
    end else begin
      sdu_ready <= next_sdu_ready;
      if (hdr_load | data_load) begin
        out_valid <= 1'b1;
        out_data  <= next_byte;
        out_last  <= next_last;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end

  // Per-slot sequence counters, cleared by logon reset
  for (genvar i = 0; i < SLOTS; i++) begin : g_seq
    always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
        seq[i] <= 8'h00;
      end else if (seq_last & (u_slot == 3'(i))) begin
        seq[i] <= seq[i] + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Unit sequencer
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state <= lhb_pkg::ST_IDLE;
      req_ready <= 1'b0;
      {u_type, u_code, u_tag, u_tag_n, u_slot, cnt} <= '0;
      {u_omit, u_type_first, u_emit_type, u_split, u_crc, u_first} <= '0;
      {integrity_sel, ext_flag} <= 2'b00;
      crc_type <= 16'h0000;
    end else begin
      req_ready <= (state == lhb_pkg::ST_IDLE) & ~take_req;
      case (state)
        lhb_pkg::ST_IDLE: begin
          if (take_req) begin
            u_type       <= req_full;
            crc_type     <= req_full;
            ext_flag     <= req_full < lhb_pkg::EXT_LIMIT;
            u_code       <= req_code;
            u_omit       <= c_omit;
            u_type_first <= ~c_omit & ~c_short;
            u_emit_type  <= ~c_omit & (~c_short | req_esc);
            u_split      <= req_split;
            u_crc        <= req_split & trail_crc;
            integrity_sel <= req_split & trail_crc;
            u_slot       <= req_slot;
            u_tag        <= req_tag;
            u_tag_n      <= tag_count(req_tag_code, ctrl[lhb_pkg::TAGLEN_LSB +: 3]);
            u_first      <= 1'b1;
            cnt          <= 3'd0;
            state <= req_bad ? lhb_pkg::ST_DRAIN :
                     c_short ? lhb_pkg::ST_CODE :
                     c_omit  ? lhb_pkg::ST_TAG : lhb_pkg::ST_TYPEH;
          end
        end
        lhb_pkg::ST_CODE: begin
          if (slot_free) begin
            state <= lhb_pkg::ST_TAG;
          end
        end
        lhb_pkg::ST_TAG: begin
          if (!tag_busy) begin
            state <= (u_emit_type & ~u_type_first) ? lhb_pkg::ST_TYPEH
                                                   : lhb_pkg::ST_DATA;
          end else if (slot_free) begin
            cnt   <= cnt + 3'd1;
            u_tag <= {u_tag[23:0], 8'h00};
          end
        end
        lhb_pkg::ST_TYPEH: begin
          if (slot_free) begin
            state <= lhb_pkg::ST_TYPEL;
          end
        end
        lhb_pkg::ST_TYPEL: begin
          if (slot_free) begin
            state <= u_type_first ? lhb_pkg::ST_TAG : lhb_pkg::ST_DATA;
          end
        end
        lhb_pkg::ST_DATA: begin
          if (take_sdu) begin
            u_first <= 1'b0;
            if (ip_resolve) begin
              u_type   <= ip_type;
              crc_type <= ip_type;
            end
            if (sdu_last) begin
              cnt   <= 3'd0;
              state <= u_split ? lhb_pkg::ST_TRAIL : lhb_pkg::ST_IDLE;
            end
          end
        end
        lhb_pkg::ST_TRAIL: begin
          if (slot_free) begin
            cnt <= cnt + 3'd1;
            if (seq_last | crc_last) begin
              state <= lhb_pkg::ST_IDLE;
            end
          end
        end
        lhb_pkg::ST_DRAIN: begin
          if (take_sdu & sdu_last) begin
            state <= lhb_pkg::ST_IDLE;
          end
        end
        default: state <= lhb_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking dc @(posedge clock); endclocking
  default disable iff (reset);

  omit_no_code_a: assert property (state == lhb_pkg::ST_CODE |-> !u_omit)
    else $error("short code state entered while type omitted");
  code_allowed_a: assert property ((state == lhb_pkg::ST_CODE) && hdr_load |->
    code_class(u_code) != lhb_pkg::RSVD_CLASS && allow[code_class(u_code)])
    else $error("unpermitted short code emitted");
  ip_resolve_a: assert property (ip_resolve && sdu_data[7:4] == lhb_pkg::IPV6_VER
    |=> crc_type == lhb_pkg::IPV6_TYPE)
    else $error("ip version not resolved to full type");
  type_gate_a: assert property (state == lhb_pkg::ST_TYPEH |-> u_emit_type)
    else $error("full type emitted when it should be absent");
  type_msb_a: assert property ((state == lhb_pkg::ST_TYPEH) && hdr_load
    |=> out_valid && out_data == $past(u_type[15:8]) && state == lhb_pkg::ST_TYPEL)
    else $error("full type high byte not sent first");
  single_trail_a: assert property (state == lhb_pkg::ST_TRAIL |-> u_split)
    else $error("trailer on unsplit unit");
  seq_step_a: assert property (seq_last |=> out_data == $past(cur_seq)
    && cur_seq == $past(cur_seq) + 8'h01 && out_last)
    else $error("sequence trailer value or advance wrong");
  seq_permit_a: assert property ((state == lhb_pkg::ST_TRAIL) && !u_crc
    |-> ctrl[lhb_pkg::SEQ_OK_BIT] && !integrity_sel)
    else $error("sequence trailer used without permission");
  reserved_err_a: assert property (take_req && code_bad
    |=> state == lhb_pkg::ST_DRAIN && cfg_error)
    else $error("reserved code request not refused");
  tag_count_a: assert property (state == lhb_pkg::ST_TAG && !tag_busy |=>
    state != lhb_pkg::ST_TAG && cnt == $past(u_tag_n))
    else $error("tag count overrun");

  esc_unit_c: cover property (state == lhb_pkg::ST_CODE && u_code == lhb_pkg::ESC_CODE);
  seq_unit_c: cover property (seq_last);
  crc_unit_c: cover property (crc_last);
  drain_unit_c: cover property (state == lhb_pkg::ST_DRAIN ##1 state == lhb_pkg::ST_IDLE);
endmodule

/* File: bench/lhb_piece_sink.sv */
`timescale 1ns/100ps
// Downstream fragmenter: takes unit bytes, stalls at random when slow
module lhb_piece_sink (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic slow,
  output logic      out_ready
);
  int seed = 43;
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      out_ready <= 1'b0;
    end else begin
      out_ready <= slow ? 1'($random(seed) % 2) : 1'b1;
    end
  end
endmodule

/* File: bench/testbench.sv */
`timescale 1ns/100ps
`define CHK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin n_fail++; \
  $display("ERROR %s expected %h seen %h", what, exp, got); end end
module testbench;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        avs_read, avs_write, avs_waitrequest, req_valid, req_ready, req_split;
  logic        req_use_crc, sdu_valid, sdu_ready, sdu_last, out_valid, out_ready, out_last;
  logic        integrity_sel, cfg_error, slow;
  logic [1:0]  req_tag_code;
  logic [2:0]  req_slot;
  logic [3:0]  avs_address, avs_byteenable;
  logic [7:0]  req_code, sdu_data, out_data;
  logic [15:0] req_type, crc_type, etype;
  logic [31:0] avs_writedata, avs_readdata, req_tag, crc_value, rd, crcv;
  logic [8:0]  q[$];
  logic [7:0]  pay[$];
  logic [7:0]  codes[4] = '{8'h0c, 8'h0d, 8'h0e, 8'h31};
  logic [15:0] types[4] = '{16'h0500, 16'h0800, 16'h0806, 16'h8100};
  logic [2:0]  slots[4] = '{3'h3, 3'h3, 3'h5, 3'h3};
  logic [7:0]  seqs[4] = '{8'h00, 8'h01, 8'h00, 8'h02};
  logic [7:0]  bad[4] = '{8'h20, 8'h48, 8'h11, 8'h0d};
  int          seed = 43;
  int          n_fail = 0;
  int          check_count = 0;

  always #5 clock = ~clock;

  lhb_core #(.SLOTS(8)) u_lhb_core (
    .clock, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .req_valid, .req_ready, .req_type, .req_code,
    .req_tag_code, .req_tag, .req_split, .req_use_crc, .req_slot, .sdu_valid, .sdu_ready,
    .sdu_data, .sdu_last, .crc_value, .out_valid, .out_ready, .out_data, .out_last,
    .integrity_sel, .crc_type, .cfg_error);
  lhb_piece_sink u_lhb_piece_sink (.clock, .reset, .slow, .out_ready);

  ////////////////////////////////////////////////////////////////////////////////
  // Output watcher: every accepted byte against the oldest note
  always @(posedge clock) begin
    if (!reset && out_valid === 1'b1 && out_ready === 1'b1) begin
      if (q.size() == 0) begin
        n_fail++;
        $display("ERROR unit byte expected none seen %h", out_data);
      end else begin
        `CHK("unit byte", q[0], {out_last, out_data})
        void'(q.pop_front());
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task summarize;
    $display("Checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task tick(inout int n);
    @(posedge clock);
    n++;
    if (n > 300) begin
      n_fail++;
      $display("ERROR wait expected done seen timeout");
      summarize();
    end
  endtask

  task bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    avs_write <= wr;
    avs_read <= !wr;
    avs_address <= a;
    avs_writedata <= wd;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) tick(n);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task hdr(input logic [7:0] b);
    q.push_back({1'b0, b});
  endtask

  task pay_gen(input int len);
    pay.delete();
    crcv = $random(seed);
    for (int i = 0; i < len; i++) begin
      pay.push_back(8'($random(seed)));
      hdr(pay[i]);
    end
  endtask

  task fin;
    q[q.size()-1][8] = 1'b1;
  endtask

  task unit(input logic [7:0] code, input logic [15:0] typ, input logic [1:0] tc,
            input logic [31:0] tag, input logic split, input logic crc, input logic [2:0] slot);
    int n;
    n = 0;
    @(posedge clock);
    {req_valid, req_code, req_type, req_tag_code} <= {1'b1, code, typ, tc};
    {req_tag, req_split, req_use_crc, req_slot, crc_value} <= {tag, split, crc, slot, crcv};
    @(posedge clock);
    while (req_ready !== 1'b1) tick(n);
    req_valid <= 1'b0;
    foreach (pay[i]) begin
      sdu_valid <= 1'b1;
      sdu_data <= pay[i];
      sdu_last <= (i == pay.size() - 1);
      n = 0;
      @(posedge clock);
      while (sdu_ready !== 1'b1) tick(n);
    end
    sdu_valid <= 1'b0;
    n = 0;
    while (q.size() != 0 || req_ready !== 1'b1) tick(n);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {avs_read, avs_write, req_valid, req_split, req_use_crc, sdu_valid, sdu_last, slow} = '0;
    {avs_address, req_tag_code, req_slot, req_code, sdu_data, req_type} = '0;
    {avs_writedata, req_tag, crc_value, crcv} = '0;
    avs_byteenable = 4'hf;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    bus(1'b0, 4'h0, 32'h0);
    `CHK("ctrl reset", 32'h0800_0000, rd)
    bus(1'b0, 4'h4, 32'h0);
    `CHK("allow reset", 32'h0, rd)
    bus(1'b1, 4'hc, 32'hffff_ffff);
    bus(1'b0, 4'hc, 32'h0);
    `CHK("unmapped read", 32'h0, rd)
    $display("Test registers done");
    // Short codes from the fixed table, unsplit
    bus(1'b1, 4'h4, 32'h4c00_7000);
    bus(1'b1, 4'h0, 32'h0800_0002);
    for (int k = 0; k < 4; k++) begin
      hdr(codes[k]);
      pay_gen(k + 1);
      fin();
      unit(codes[k], 16'h0, 2'h0, 32'h0, 1'b0, 1'b0, 3'h0);
      `CHK("crc type", types[k], crc_type)
    end
    // Common IP code resolved from the first payload byte
    hdr(8'h30);
    pay_gen(2);
    pay[0][7:4] = 4'h6;
    q[1][7:4] = 4'h6;
    fin();
    unit(8'h30, 16'h0, 2'h0, 32'h0, 1'b0, 1'b0, 3'h0);
    `CHK("ip type", 16'h86dd, crc_type)
    $display("Test short codes done");
    // Escape: tags from controller length, then full type, under stalls
    slow <= 1'b1;
    bus(1'b1, 4'h0, 32'h0800_0022);
    for (int k = 0; k < 2; k++) begin
      etype = k ? 16'h05ff : 16'h0600;
      hdr(8'hff);
      hdr(8'ha1);
      hdr(8'hb2);
      hdr(etype[15:8]);
      hdr(etype[7:0]);
      pay_gen(3);
      fin();
      unit(8'hff, etype, 2'h1, 32'ha1b2_c3d4, 1'b0, 1'b0, 3'h0);
      bus(1'b0, 4'h8, 32'h0);
      `CHK("extension flag", 1'(k), rd[2])
    end
    $display("Test escape done");
    // Full type mode with one tag, then omit mode
    bus(1'b1, 4'h0, 32'h0800_0000);
    hdr(8'h86);
    hdr(8'hdd);
    hdr(8'h5a);
    pay_gen(2);
    fin();
    unit(8'h0, 16'h86dd, 2'h2, 32'h5a00_0000, 1'b0, 1'b0, 3'h0);
    bus(1'b1, 4'h0, 32'h0800_0001);
    hdr(8'h5a);
    pay_gen(2);
    fin();
    unit(8'h0d, 16'h0800, 2'h2, 32'h5a00_0000, 1'b0, 1'b0, 3'h0);
    `CHK("default type", 16'h0800, crc_type)
    $display("Test full and omit done");
    // Split units: per-slot sequence trailer, then CRC trailer
    bus(1'b1, 4'h0, 32'h0800_0006);
    for (int k = 0; k < 4; k++) begin
      hdr(8'h0d);
      pay_gen(2);
      hdr(seqs[k]);
      fin();
      unit(8'h0d, 16'h0, 2'h0, 32'h0, 1'b1, 1'b0, slots[k]);
      `CHK("integrity select", 1'b0, integrity_sel)
    end
    bus(1'b1, 4'h0, 32'h0800_000e);
    hdr(8'h0d);
    pay_gen(3);
    for (int b = 3; b >= 0; b--) hdr(crcv[8*b +: 8]);
    fin();
    unit(8'h0d, 16'h0, 2'h0, 32'h0, 1'b1, 1'b1, 3'h3);
    `CHK("integrity select", 1'b1, integrity_sel)
    slow <= 1'b0;
    $display("Test split done");
    // Refused: reserved codes, a code not allowed, split with no trailer allowed
    bus(1'b1, 4'h0, 32'h0800_0002);
    for (int k = 0; k < 4; k++) begin
      pay_gen(2);
      q.delete();
      unit(bad[k], 16'h0, 2'h0, 32'h0, 1'(k == 3), 1'b0, 3'h1);
      `CHK("config error", 1'b1, cfg_error)
      bus(1'b1, 4'h8, 32'h0000_0001);
      bus(1'b0, 4'h8, 32'h0);
      `CHK("error cleared", 1'b0, rd[0])
    end
    $display("Test refusals done");
    summarize();
  end
endmodule
